// [jtfl_map.svh]
// constants for the test access port and output float block
// ----------------------------------------------------------------------
// Overview of operation
// - tms and tdi are sampled on every rising edge of the test clock.
// - data shifts out on tdo, which changes only on falling test clock.
// - tdo stays undriven except while register data is shifting.
// - with the test reset high the scan system controls the device.
// - test reset low or open: normal mode, test pins ignored.
// - test reset high: emulator pins are events, direction set by scan.
// - test reset low, float pin low: every driver, tdo too, floats.
// ----------------------------------------------------------------------
`ifndef JTFL_MAP_SVH
`define JTFL_MAP_SVH
`define JTFL_IR_W 4
`define JTFL_IR_RST 4'h1
`define JTFL_IR_BYPASS 4'hf
`define JTFL_IR_EMUCTL 4'h8
`define JTFL_EMU_W 4
`define JTFL_EMU_RST 4'h0
`define JTFL_FUNC_W 8
// synchronisers leave reset at the pins' pull levels: emulator pins, tdi
// and tms high, test reset and test clock low, so no false float follows
`define JTFL_SYNC_RST 6'h36
`endif

// [jtfl_pkg.sv]
// types for the test access port and output float block
package jtfl_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SDS, CDR, SHDR, E1DR, PDR, E2DR, UDR,
    SIS, CIR, SHIR, E1IR, PIR, E2IR, UIR
  } jtfl_tap_e;
  // emulator pin control: output enables and output levels
  typedef struct packed {
    logic a_oe;
    logic b_oe;
    logic a_out;
    logic b_out;
  } jtfl_emu_s;
endpackage

// [jtfl_top.sv]
// tap pin logic, emulator pins and global output float
`timescale 1ns/1ns
`include "jtfl_map.svh"
module jtfl_top (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_i,
  input wire logic emu_a_i,
  input wire logic emu_b_i,
  input wire logic [`JTFL_FUNC_W-1:0] func_out_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic emu_a_o,
  output logic emu_a_oe_o,
  output logic emu_b_o,
  output logic emu_b_oe_o,
  output logic [`JTFL_FUNC_W-1:0] func_out_o,
  output logic func_oe_o,
  output logic scan_mode_o,
  output logic emu_a_evt_o,
  output logic emu_b_evt_o
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic tck_d1_q;
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= `JTFL_SYNC_RST;
      s2_q <= `JTFL_SYNC_RST;
      tck_d1_q <= 1'b0;
    end
    else
    begin
      s1_q <= {emu_b_i, emu_a_i, trst_i, tdi_i, tms_i, tck_i};
      s2_q <= s1_q;
      tck_d1_q <= s2_q[0];
    end
  end
  logic tck_s, tms_s, tdi_s, trst_s, emu_a_s, emu_b_s;
  assign {emu_b_s, emu_a_s, trst_s, tdi_s, tms_s, tck_s} = s2_q;
  logic scan_en;
  assign scan_en = trst_s;
  logic tck_rise, tck_fall;
  assign tck_rise = scan_en && tck_s && !tck_d1_q;
  assign tck_fall = scan_en && !tck_s && tck_d1_q;
  // ----------------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------------
  function automatic jtfl_pkg::jtfl_tap_e next_st(
    input jtfl_pkg::jtfl_tap_e s, input logic m);
    case (s)
      jtfl_pkg::TLR: next_st = m ? jtfl_pkg::TLR : jtfl_pkg::RTI;
      jtfl_pkg::RTI: next_st = m ? jtfl_pkg::SDS : jtfl_pkg::RTI;
      jtfl_pkg::SDS: next_st = m ? jtfl_pkg::SIS : jtfl_pkg::CDR;
      jtfl_pkg::CDR: next_st = m ? jtfl_pkg::E1DR : jtfl_pkg::SHDR;
      jtfl_pkg::SHDR: next_st = m ? jtfl_pkg::E1DR : jtfl_pkg::SHDR;
      jtfl_pkg::E1DR: next_st = m ? jtfl_pkg::UDR : jtfl_pkg::PDR;
      jtfl_pkg::PDR: next_st = m ? jtfl_pkg::E2DR : jtfl_pkg::PDR;
      jtfl_pkg::E2DR: next_st = m ? jtfl_pkg::UDR : jtfl_pkg::SHDR;
      jtfl_pkg::UDR: next_st = m ? jtfl_pkg::SDS : jtfl_pkg::RTI;
      jtfl_pkg::SIS: next_st = m ? jtfl_pkg::TLR : jtfl_pkg::CIR;
      jtfl_pkg::CIR: next_st = m ? jtfl_pkg::E1IR : jtfl_pkg::SHIR;
      jtfl_pkg::SHIR: next_st = m ? jtfl_pkg::E1IR : jtfl_pkg::SHIR;
      jtfl_pkg::E1IR: next_st = m ? jtfl_pkg::UIR : jtfl_pkg::PIR;
      jtfl_pkg::PIR: next_st = m ? jtfl_pkg::E2IR : jtfl_pkg::PIR;
      jtfl_pkg::E2IR: next_st = m ? jtfl_pkg::UIR : jtfl_pkg::SHIR;
      jtfl_pkg::UIR: next_st = m ? jtfl_pkg::SDS : jtfl_pkg::RTI;
      default: next_st = jtfl_pkg::TLR;
    endcase
  endfunction
  jtfl_pkg::jtfl_tap_e st_q;
  // walk the state machine; held in reset while scan is off
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_q <= jtfl_pkg::TLR;
    else if (!scan_en)
      st_q <= jtfl_pkg::TLR;
    else if (tck_rise)
      st_q <= next_st(st_q, tms_s);
  end
  // ----------------------------------------------------------------------
  // instruction and data registers
  // ----------------------------------------------------------------------
  logic [`JTFL_IR_W-1:0] ir_sh_q, ir_q;
  logic [`JTFL_EMU_W-1:0] dr_sh_q, emu_ctl_q;
  logic byp_q;
  logic sel_emu;
  assign sel_emu = (ir_q == `JTFL_IR_EMUCTL);
  // capture, shift and update on rising test clock edges
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ir_sh_q <= `JTFL_IR_RST;
      ir_q <= `JTFL_IR_RST;
      dr_sh_q <= `JTFL_EMU_RST;
      emu_ctl_q <= `JTFL_EMU_RST;
      byp_q <= 1'b0;
    end
    else if (!scan_en || (tck_rise && st_q == jtfl_pkg::TLR))
    begin
      ir_q <= `JTFL_IR_RST;
      emu_ctl_q <= `JTFL_EMU_RST;
    end
    else if (tck_rise)
    begin
      case (st_q)
        jtfl_pkg::CIR: ir_sh_q <= `JTFL_IR_RST;
        jtfl_pkg::SHIR: ir_sh_q <= {tdi_s, ir_sh_q[`JTFL_IR_W-1:1]};
        jtfl_pkg::UIR: ir_q <= ir_sh_q;
        jtfl_pkg::CDR:
        begin
          dr_sh_q <= emu_ctl_q;
          byp_q <= 1'b0;
        end
        jtfl_pkg::SHDR:
        begin
          if (sel_emu)
            dr_sh_q <= {tdi_s, dr_sh_q[`JTFL_EMU_W-1:1]};
          else
            byp_q <= tdi_s;
        end
        jtfl_pkg::UDR: if (sel_emu) emu_ctl_q <= dr_sh_q;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // output float and pin drivers
  // ----------------------------------------------------------------------
  logic float_c;
  assign float_c = !trst_s && !emu_b_s;
  logic shifting;
  assign shifting = (st_q == jtfl_pkg::SHDR) || (st_q == jtfl_pkg::SHIR);
  // tdo changes only on falling test clock edges
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (float_c || !scan_en)
      tdo_oe_o <= 1'b0;
    else if (tck_fall)
    begin
      tdo_oe_o <= shifting;
      if (st_q == jtfl_pkg::SHIR)
        tdo_o <= ir_sh_q[0];
      else if (sel_emu)
        tdo_o <= dr_sh_q[0];
      else
        tdo_o <= byp_q;
    end
  end
  jtfl_pkg::jtfl_emu_s emu_c;
  assign emu_c = emu_ctl_q;
  // emulator pins act as event lines only in scan mode
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      emu_a_o <= 1'b0;
      emu_a_oe_o <= 1'b0;
      emu_b_o <= 1'b0;
      emu_b_oe_o <= 1'b0;
      emu_a_evt_o <= 1'b0;
      emu_b_evt_o <= 1'b0;
    end
    else
    begin
      emu_a_o <= emu_c.a_out;
      emu_b_o <= emu_c.b_out;
      emu_a_oe_o <= scan_en && emu_c.a_oe;
      emu_b_oe_o <= scan_en && emu_c.b_oe;
      emu_a_evt_o <= scan_en && !emu_c.a_oe && emu_a_s;
      emu_b_evt_o <= scan_en && !emu_c.b_oe && emu_b_s;
    end
  end
  // functional outputs pass through unless floated
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      func_out_o <= '0;
      func_oe_o <= 1'b0;
      scan_mode_o <= 1'b0;
    end
    else
    begin
      func_out_o <= func_out_i;
      func_oe_o <= !float_c;
      scan_mode_o <= scan_en;
    end
  end
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  float_kills_oe_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    float_c |=> !func_oe_o && !tdo_oe_o)
    else $error("outputs driven during float");
  tdo_fall_only_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !tck_fall |=> $stable(tdo_o))
    else $error("tdo changed off a falling edge");
  // enable may only turn on from a shift state and must drop on the
  // first falling test clock seen outside one
  tdo_idle_z_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(tdo_oe_o) |-> $past(shifting))
    else $error("tdo enabled outside shift");
  tdo_oe_drop_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (tck_fall && !shifting) |=> !tdo_oe_o)
    else $error("tdo kept driven after shift");
  func_ignore_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !scan_en |=> st_q == jtfl_pkg::TLR && !tdo_oe_o)
    else $error("tap active with test reset low");
  scan_mode_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    scan_en |=> scan_mode_o)
    else $error("scan mode not shown");
  tms_reset_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (tck_rise && tms_s && st_q == jtfl_pkg::SIS && scan_en)
    |=> st_q == jtfl_pkg::TLR)
    else $error("tap failed to reach reset");
  tdi_sample_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (tck_rise && st_q == jtfl_pkg::SHIR && scan_en)
    |=> ir_sh_q[`JTFL_IR_W-1] == $past(tdi_s))
    else $error("tdi not sampled");
  emu_dir_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !scan_en |=> !emu_a_oe_o && !emu_b_oe_o)
    else $error("emulator pin driven outside scan");
  float_cov_c: cover property (@(posedge clock_i) float_c ##1 !func_oe_o);
  shift_cov_c: cover property (@(posedge clock_i) tdo_oe_o);
  emu_cov_c: cover property (@(posedge clock_i) emu_a_oe_o);
endmodule

// [jtfl_ctl.sv]
// behavioural scan controller model for the test pins
`timescale 1ns/1ns
module jtfl_ctl (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  // clock stands still low outside frames, tdi idles at its pull-up
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_o = 1'b0;
  end
  task automatic set_trst(input logic v);
    trst_o = v;
  endtask
  // one frame of n test clocks, tdo looked at just before each rise
  task automatic run(input int n, input logic [15:0] tms_v,
    input logic [15:0] tdi_v, output logic [15:0] tdo_v,
    output logic [15:0] oe_v);
    for (int i = 0; i < n; i++)
    begin
      tms_o = tms_v[i];
      tdi_o = tdi_v[i];
      #160;
      tdo_v[i] = tdo_oe_i ? tdo_i : !tdo_i; // undriven tdo reads inverted
      oe_v[i] = tdo_oe_i;
      tck_o = 1'b1;
      #160;
      tck_o = 1'b0;
    end
    tdi_o = 1'b1;
  endtask
endmodule

// [jtfl_top_bench.sv]
// self-checking bench for the scan pins and output float block
`timescale 1ns/1ns
module jtfl_top_bench;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ext_a = 1'b1;
  logic ext_b = 1'b1;
  logic [7:0] fin = 8'h00;
  logic tck, tms, tdi, trst, tdo, tdo_oe, a_o, a_oe, b_o, b_oe;
  logic fo_e, scan, ev_a, ev_b;
  logic [7:0] fout;
  logic [15:0] tv, ov;
  logic [3:0] v, got;
  logic [3:0] model_q[$]; // expected capture values of the control register
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire emu_a = a_oe ? a_o : ext_a;
  wire emu_b = b_oe ? b_o : ext_b;
  always #20 clock_i = ~clock_i;
  jtfl_ctl u_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_o(trst),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  jtfl_top u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_i(trst), .emu_a_i(emu_a),
    .emu_b_i(emu_b), .func_out_i(fin), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .emu_a_o(a_o), .emu_a_oe_o(a_oe), .emu_b_o(b_o), .emu_b_oe_o(b_oe),
    .func_out_o(fout), .func_oe_o(fo_e), .scan_mode_o(scan),
    .emu_a_evt_o(ev_a), .emu_b_evt_o(ev_b));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  // load the instruction register, lsb first
  task automatic ir(input logic [3:0] i);
    step(1);
    u_ctl.run(10, 16'h0183, 16'hff0f | (i << 4), tv, ov);
    check("ir_oe", ov[7:0], 8'hf0);
  endtask
  // one data register frame of four bits
  task automatic dr(input logic [3:0] d, output logic [3:0] q);
    step(1);
    u_ctl.run(9, 16'h00c1, 16'hff87 | (d << 3), tv, ov);
    q = tv[6:3];
    check("dr_oe", ov[7:0], 8'h78);
  endtask
  // hang guard
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  initial
  begin
    void'($urandom(63408));
    step(16);
    check("rst_oe", {fo_e, tdo_oe}, 16'h0);
    rst_b_i = 1'b1;
    step(6);
    for (int k = 0; k < 6; k++)
    begin
      fin = $urandom;
      step(1);
      check("func", {fo_e, scan, fout}, {2'b10, fin});
    end
    u_ctl.run(10, 16'h0183, 16'hffff, tv, ov);
    check("ignored", ov[9:0], 16'h0);
    check("evt_off", {ev_a, ev_b}, 16'h0);
    ext_b = 1'b0; // float asked with pin b low
    step(6);
    check("float", {fo_e, tdo_oe, b_oe}, 16'h0);
    ext_b = 1'b1;
    step(6);
    check("unfloat", fo_e, 16'h1);
    u_ctl.set_trst(1'b1);
    step(6);
    check("scan_on", scan, 16'h1);
    // out through select-ir straight back to reset, then idle
    u_ctl.run(6, 16'h001e, 16'hffff, tv, ov);
    check("tlr_oe", ov[5:0], 16'h0);
    ir(4'h8);
    model_q.push_back(4'h0); // control register starts cleared
    for (int k = 0; k < 4; k++)
    begin
      v = $urandom;
      if (k == 0)
        v[3:2] = 2'b00;
      dr(v, got);
      check("dr_out", got, model_q.pop_front());
      model_q.push_back(v);
      step(4);
      check("emu", {a_oe, b_oe, a_o, b_o}, v);
      check("evt_a", ev_a, !v[3] & ext_a);
      check("evt_b", ev_b, !v[2] & ext_b);
      check("idle_oe", tdo_oe, 16'h0);
    end
    ir(4'hf);
    dr(4'ha, got);
    check("bypass", got, 4'h4);
    u_ctl.set_trst(1'b0);
    step(6);
    check("scan_off", {scan, b_oe, tdo_oe}, 16'h0);
    report_and_stop;
  end
endmodule
